/* File: src/nandh_pkg.sv */
// Constants, types and helpers for the NAND flash host controller.
// Assumes a single 250 MHz clock and an asynchronous flash part on the far side.
package nandh_pkg;

  // Array organisation of the attached device
  localparam int PLANES      = 2;
  localparam int BLOCKS      = 1024;
  localparam int PAGES       = 256;
  localparam int MAIN_BYTES  = 8192;
  localparam int SPARE_BYTES = 448;

  // Address field positions and widths
  localparam int COL_LSB     = 0;
  localparam int COL_W       = 14;
  localparam int PAGE_LSB    = 14;
  localparam int PAGE_W      = 8;
  localparam int PLANE_LSB   = 22;
  localparam int BLOCK_LSB   = 23;
  localparam int BLOCK_W     = 11;
  localparam int ADDR_W      = 34;
  localparam logic [2:0] ADDR_LAST = 3'h4;

  // Bits that must be low in the second and fifth address cycles
  localparam logic [7:0] MASK_CYC2 = 8'h3F;
  localparam logic [7:0] MASK_CYC5 = 8'h0F;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  // Strobe timing; times in ns, counts derived from the clock period
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int STROBE_LOW_NS  = 20;
  localparam int STROBE_HIGH_NS = 20;
  localparam int BUSY_GUARD_NS  = 100;
  localparam int LOW_CYCLES   = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HIGH_CYCLES  = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GUARD_CYCLES = (BUSY_GUARD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Read buffer shape
  localparam int RD_FIFO_W = 8;
  localparam int RD_FIFO_D = 4;

  // Host request kinds
  typedef enum logic [2:0] {
    OP_CMD    = 3'h0,
    OP_ADDR1  = 3'h1,
    OP_ADDR5  = 3'h2,
    OP_WDATA  = 3'h3,
    OP_RDATA  = 3'h4,
    OP_WAITRB = 3'h5
  } nandh_op_e;

  // Controller states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_LOW     = 5'h02,
    ST_HIGH    = 5'h04,
    ST_GUARD   = 5'h08,
    ST_WAITRDY = 5'h10
  } nandh_state_e;

  // Pack column, page, plane and block into the flat address
  function automatic logic [ADDR_W-1:0] makeAddr(input logic [COL_W-1:0]   col,
                                                 input logic [PAGE_W-1:0]  page,
                                                 input logic               plane,
                                                 input logic [BLOCK_W-1:0] block);
    makeAddr = {block, plane, page, col};
  endfunction

  // Byte sent in a given address cycle, unused bits forced low
  function automatic logic [7:0] addrByte(input logic [ADDR_W-1:0] a, input logic [2:0] idx);
    case (idx)
      3'h0:    addrByte = a[7:0];
      3'h1:    addrByte = {2'h0, a[13:8]};
      3'h2:    addrByte = a[21:14];
      3'h3:    addrByte = a[29:22];
      3'h4:    addrByte = {4'h0, a[33:30]};
      default: addrByte = 8'h00;
    endcase
  endfunction

  // Mask for a raw address byte by its position in the sequence
  function automatic logic [7:0] addrMask(input logic [2:0] idx);
    case (idx)
      3'h1:    addrMask = MASK_CYC2;
      3'h4:    addrMask = MASK_CYC5;
      default: addrMask = MASK_FULL;
    endcase
  endfunction

endpackage

/* File: src/nandh_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides on the same clock; storage is flip-flops.
`timescale 1ns/1ps
`default_nettype none
module nandh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wrPtr;
  logic [PW-1:0]    next_rdPtr;
  logic [PW:0]      next_count;
  logic             doWr;
  logic             doRd;

  // Honest full and empty from the occupancy count
  assign inReady  = (count < (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  // Pointer and count update
  always_comb begin
    next_wrPtr = doWr ? ((wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1) : wrPtr;
    next_rdPtr = doRd ? ((rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1) : rdPtr;
    next_count = count + (PW+1)'(doWr) - (PW+1)'(doRd);
  end

  // Register pointers and count
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule // nandh_fifo
`default_nettype wire

/* File: src/nandh_ctrl.sv */
// Host controller that drives an asynchronous NAND flash over its pins.
// Assumes the flash sits on the pins directly; bus and ready line are outside this clock.
`timescale 1ns/1ps
`default_nettype none
module nandh_ctrl (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Request port
  input  wire logic                        reqValid,
  output logic                             reqReady,
  input  wire logic [2:0]                  reqOp,
  input  wire logic [7:0]                  reqByte,
  input  wire logic [nandh_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic                        reqWaitReady,
  // Read data port
  output logic                             rdValid,
  input  wire logic                        rdReady,
  output logic [7:0]                       rdData,
  // Host level controls and status
  input  wire logic                        chipSelect,
  input  wire logic                        writeAllow,
  output logic                             devReady,
  // Flash pins
  output logic                             chipEnableN,
  output logic                             cmdLatch,
  output logic                             addrLatch,
  output logic                             writeStrobeN,
  output logic                             read_strobe_n,
  output logic                             writeProtectN,
  input  wire logic                        readyBusyN,
  input  wire logic [7:0]                  byteBusIn,
  output logic [7:0]                       byteBusOut,
  output logic                             byteBusOe
);
  localparam logic [7:0] LOW_CNT   = 8'(nandh_pkg::LOW_CYCLES - 1);
  localparam logic [7:0] HIGH_CNT  = 8'(nandh_pkg::HIGH_CYCLES - 1);
  localparam logic [7:0] GUARD_CNT = 8'(nandh_pkg::GUARD_CYCLES - 1);

  nandh_pkg::nandh_state_e state, next_state;
  logic [7:0]                    cnt, next_cnt;
  logic [2:0]                    op, next_op;
  logic [7:0]                    curByte, next_curByte;
  logic [nandh_pkg::ADDR_W-1:0]  curAddr, next_curAddr;
  logic [2:0]                    byteIdx, next_byteIdx;
  logic [2:0]                    addrCyc, next_addrCyc;
  logic                          cmdLatchR, next_cmdLatch;
  logic                          addrLatchR, next_addrLatch;
  logic                          weN, next_weN;
  logic                          readN, next_readN;
  logic                          ceN, next_ceN;
  logic                          wpN, next_wpN;
  logic [7:0]                    busOut, next_busOut;
  logic                          busOe, next_busOe;
  logic [2:0]                    rbSync;
  logic [7:0]                    busSync [3];
  logic                          rdyR, next_rdy;
  logic                          accept;
  logic                          isRead;
  logic                          busStable;
  logic                          fifoInValid;
  logic                          fifoInReady;

  // Outputs from registers
  assign chipEnableN   = ceN;
  assign cmdLatch      = cmdLatchR;
  assign addrLatch     = addrLatchR;
  assign writeStrobeN  = weN;
  assign read_strobe_n = readN;
  assign writeProtectN = wpN;
  assign byteBusOut    = busOut;
  assign byteBusOe     = busOe;
  assign devReady      = rdyR;

  // Ready line and bus pass three flops; second and third must agree
  always_ff @(posedge clk) begin
    if (srst) begin
      rbSync     <= 3'h0;
      busSync[0] <= 8'h00;
      busSync[1] <= 8'h00;
      busSync[2] <= 8'h00;
    end else begin
      rbSync     <= {rbSync[1:0], readyBusyN};
      busSync[0] <= byteBusIn;
      busSync[1] <= busSync[0];
      busSync[2] <= busSync[1];
    end
  end

  assign busStable = (busSync[1] == busSync[2]);
  assign next_rdy  = (rbSync[1] == rbSync[2]) ? rbSync[2] : rdyR;
  assign isRead    = (op == nandh_pkg::OP_RDATA);

  // Accept when ready is met and a read has room to land
  always_comb begin
    reqReady = (state == nandh_pkg::ST_IDLE)
               && !(reqWaitReady && !rdyR)
               && !((reqOp == nandh_pkg::OP_RDATA) && !fifoInReady);
  end
  assign accept      = reqValid && reqReady;
  assign fifoInValid = (state == nandh_pkg::ST_LOW) && isRead && (cnt == 8'h00) && busStable;

  // Next state of the strobe sequencer
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_op        = op;
    next_curByte   = curByte;
    next_curAddr   = curAddr;
    next_byteIdx   = byteIdx;
    next_addrCyc   = addrCyc;
    next_cmdLatch  = cmdLatchR;
    next_addrLatch = addrLatchR;
    next_weN       = weN;
    next_readN     = readN;
    next_busOut    = busOut;
    next_busOe     = busOe;
    next_wpN       = writeAllow;
    next_ceN       = !(chipSelect || (state != nandh_pkg::ST_IDLE) || reqValid);
    case (state)
      nandh_pkg::ST_IDLE: begin
        if (accept) begin
          next_op      = reqOp;
          next_curByte = reqByte;
          next_curAddr = reqAddr;
          next_byteIdx = 3'h0;
          next_cnt     = LOW_CNT;
          next_state   = nandh_pkg::ST_LOW;
          // Separate cycle per byte kind on the one bus
          next_cmdLatch  = (reqOp == nandh_pkg::OP_CMD);
          next_addrLatch = (reqOp == nandh_pkg::OP_ADDR1) || (reqOp == nandh_pkg::OP_ADDR5);
          next_weN       = (reqOp == nandh_pkg::OP_RDATA);
          next_readN     = (reqOp != nandh_pkg::OP_RDATA);
          next_busOe     = (reqOp != nandh_pkg::OP_RDATA);
          case (reqOp)
            nandh_pkg::OP_ADDR1: next_busOut = reqByte & nandh_pkg::addrMask(addrCyc);
            nandh_pkg::OP_ADDR5: next_busOut = nandh_pkg::addrByte(reqAddr, 3'h0);
            default:             next_busOut = reqByte;
          endcase
          if (reqOp == nandh_pkg::OP_CMD) begin
            next_addrCyc = 3'h0;
          end
          if (reqOp == nandh_pkg::OP_WAITRB) begin
            next_cmdLatch  = 1'b0;
            next_addrLatch = 1'b0;
            next_weN       = 1'b1;
            next_readN     = 1'b1;
            next_busOe     = 1'b0;
            next_cnt       = GUARD_CNT;
            next_state     = nandh_pkg::ST_GUARD;
          end
        end
      end
      nandh_pkg::ST_LOW: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (!isRead || busStable) begin
          // Rising edge is the device's sampling moment
          next_weN   = 1'b1;
          next_readN = 1'b1;
          next_cnt   = HIGH_CNT;
          next_state = nandh_pkg::ST_HIGH;
          if (addrLatchR && (addrCyc != 3'h7)) begin
            next_addrCyc = addrCyc + 3'h1;
          end
        end
      end
      nandh_pkg::ST_HIGH: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if ((op == nandh_pkg::OP_ADDR5) && (byteIdx != nandh_pkg::ADDR_LAST)) begin
          // Next of the five address cycles
          next_byteIdx = byteIdx + 3'h1;
          next_busOut  = nandh_pkg::addrByte(curAddr, byteIdx + 3'h1);
          next_weN     = 1'b0;
          next_cnt     = LOW_CNT;
          next_state   = nandh_pkg::ST_LOW;
        end else begin
          next_cmdLatch  = 1'b0;
          next_addrLatch = 1'b0;
          next_busOe     = 1'b0;
          next_state     = nandh_pkg::ST_IDLE;
        end
      end
      nandh_pkg::ST_GUARD: begin
        // Give the device time to pull the ready line low
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else begin
          next_state = nandh_pkg::ST_WAITRDY;
        end
      end
      nandh_pkg::ST_WAITRDY: begin
        if (rdyR) begin
          next_state = nandh_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = nandh_pkg::ST_IDLE;
      end
    endcase
  end

  // Register sequencer and pins
  always_ff @(posedge clk) begin
    if (srst) begin
      state      <= nandh_pkg::ST_IDLE;
      cnt        <= 8'h00;
      op         <= 3'h0;
      curByte    <= 8'h00;
      curAddr    <= '0;
      byteIdx    <= 3'h0;
      addrCyc    <= 3'h0;
      cmdLatchR  <= 1'b0;
      addrLatchR <= 1'b0;
      weN        <= 1'b1;
      readN      <= 1'b1;
      ceN        <= 1'b1;
      wpN        <= 1'b0;
      busOut     <= 8'h00;
      busOe      <= 1'b0;
      rdyR       <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      op         <= next_op;
      curByte    <= next_curByte;
      curAddr    <= next_curAddr;
      byteIdx    <= next_byteIdx;
      addrCyc    <= next_addrCyc;
      cmdLatchR  <= next_cmdLatch;
      addrLatchR <= next_addrLatch;
      weN        <= next_weN;
      readN      <= next_readN;
      ceN        <= next_ceN;
      wpN        <= next_wpN;
      busOut     <= next_busOut;
      busOe      <= next_busOe;
      rdyR       <= next_rdy;
    end
  end

  // Read bytes buffered toward the user
  nandh_fifo #(
    .WIDTH (nandh_pkg::RD_FIFO_W),
    .DEPTH (nandh_pkg::RD_FIFO_D)
  ) u_rdFifo (
    .clk      (clk),
    .srst     (srst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (busSync[2]),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData)
  );
endmodule // nandh_ctrl
`default_nettype wire

/* File: sim/nandh_flash_model.sv */
// Behavioural flash device seen from its pins, for the host bench.
// Assumes the host pins change only on the bench clock edges.
`timescale 1ns/1ps
`default_nettype none
module nandh_flash_model #(
  parameter int BUSY_CYCLES = 200
) (
  // Clock for busy timing
  input  wire logic        clk,
  // Host pins
  input  wire logic        ceN,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        weN,
  input  wire logic        readN,
  input  wire logic        wpN,
  input  wire logic [7:0]  busIn,
  // Device drives
  output logic      [7:0]  busOut,
  output logic             busOe,
  output logic             pullLow,
  // Captured registers
  output logic      [7:0]  lastCmd,
  output logic      [7:0]  lastData,
  output logic      [39:0] addrReg
);
  logic [2:0]  addrCount = 3'h0;
  logic [15:0] rdCount   = 16'h0;
  logic [15:0] rdMark    = 16'h0;
  logic        startTog  = 1'b0;
  logic        startSeen = 1'b0;
  int          busyCnt   = 0;

  // Known register contents at power-up
  initial begin
    lastCmd  = 8'h00;
    lastData = 8'h00;
    addrReg  = 40'h00_0000_0000;
    busOut   = 8'h00;
  end

  // Latch command, address or data on the write strobe rise
  always @(posedge weN) begin
    if (!ceN && cle) begin
      lastCmd   <= busIn;
      addrCount <= 3'h0;
      // Program or erase confirm starts only when not protected
      if ((busIn == 8'h10 || busIn == 8'hD0) && wpN && busyCnt == 0) begin
        startTog <= !startTog;
      end
    end else if (!ceN && ale) begin
      if (addrCount < 3'h5) begin
        addrReg[8*addrCount+:8] <= busIn;
        addrCount               <= addrCount + 3'h1;
      end
      rdMark <= rdCount;
    end else if (!ceN) begin
      lastData <= busIn;
    end
  end

  // Each read strobe fall puts out the next column byte
  always @(negedge readN) begin
    if (!ceN) begin
      busOut  <= (addrReg[7:0] + 8'(rdCount - rdMark)) ^ 8'h3C;
      rdCount <= rdCount + 16'h1;
    end
  end

  // Array operation runs on its own, select ignored
  always @(posedge clk) begin
    startSeen <= startTog;
    if (startSeen != startTog) begin
      busyCnt <= BUSY_CYCLES;
    end else if (busyCnt != 0) begin
      busyCnt <= busyCnt - 1;
    end
  end

  // Bus released unless selected and reading; ready line open drain
  // Deselected while ready: nothing latched, device free to sleep
  assign busOe   = !ceN && !readN;
  assign pullLow = busyCnt != 0;
endmodule // nandh_flash_model
`default_nettype wire

/* File: sim/nandh_ctrl_assertions.sv */
// Pin protocol checks for the flash host controller.
// Assumes binding onto nandh_ctrl, one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module nandh_ctrl_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Request side
  input wire logic       reqValid,
  input wire logic       reqReady,
  input wire logic       reqWaitReady,
  input wire logic       writeAllow,
  input wire logic       devReady,
  // Flash pins
  input wire logic       chipEnableN,
  input wire logic       cmdLatch,
  input wire logic       addrLatch,
  input wire logic       writeStrobeN,
  input wire logic       read_strobe_n,
  input wire logic       writeProtectN,
  input wire logic [7:0] byteBusOut,
  input wire logic       byteBusOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Latch strobes around the write strobe rise
  property p_cmd_latch;
    $rose(writeStrobeN) && cmdLatch |-> byteBusOe && !addrLatch && $stable(byteBusOut)
      && $stable(cmdLatch);
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command byte not held at strobe");
  property p_addr_latch;
    $rose(writeStrobeN) && addrLatch |-> byteBusOe && !cmdLatch && $stable(byteBusOut)
      && $stable(addrLatch);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address byte not held at strobe");
  // Write strobe shape: data steady while low, then a full high phase
  property p_we_low;
    $fell(writeStrobeN) |=> (!writeStrobeN && $stable(byteBusOut))[*4] ##1 writeStrobeN;
  endproperty
  a_we_low: assert property (p_we_low) else $error("write strobe low phase wrong");
  property p_we_high;
    $rose(writeStrobeN) |-> writeStrobeN[*5];
  endproperty
  a_we_high: assert property (p_we_high) else $error("write strobe high phase short");
  // Command and address cycles kept apart
  property p_separate;
    cmdLatch |-> !addrLatch;
  endproperty
  a_separate: assert property (p_separate) else $error("both latch enables high");
  // Host off the bus while the device drives it
  property p_no_clash;
    !read_strobe_n |-> !byteBusOe && writeStrobeN;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("host drives bus during read");
  property p_ce_active;
    !writeStrobeN || !read_strobe_n |-> !chipEnableN;
  endproperty
  a_ce_active: assert property (p_ce_active) else $error("strobe without chip enable");
  property p_read_pulse;
    $fell(read_strobe_n) |=> (!read_strobe_n)[*4];
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read strobe pulse too short");
  property p_wait_ready;
    reqValid && reqReady && reqWaitReady |-> devReady;
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("request taken while busy");
  property p_wp_level;
    1'b1 |=> writeProtectN == $past(writeAllow);
  endproperty
  a_wp_level: assert property (p_wp_level) else $error("protect pin not following level");

  // Main scenarios reached
  c_cmd: cover property ($rose(writeStrobeN) && cmdLatch);
  c_addr: cover property ($rose(writeStrobeN) && addrLatch);
  c_read: cover property ($fell(read_strobe_n));
  c_wait: cover property (reqValid && reqReady && reqWaitReady);
endmodule // nandh_ctrl_assertions

bind nandh_ctrl nandh_ctrl_assertions u_nandh_ctrl_assertions (
  .clk(clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady),
  .reqWaitReady(reqWaitReady), .writeAllow(writeAllow), .devReady(devReady),
  .chipEnableN(chipEnableN), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
  .writeStrobeN(writeStrobeN), .read_strobe_n(read_strobe_n),
  .writeProtectN(writeProtectN), .byteBusOut(byteBusOut), .byteBusOe(byteBusOe)
);
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench: host controller against the flash device model.
// Assumes package, design, model and checker compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqWaitReady = 1'b0;
  logic        rdReady = 1'b0, chipSelect = 1'b1, writeAllow = 1'b0;
  logic [2:0]  reqOp = 3'h0;
  logic [7:0]  reqByte = 8'h00, lastLevel = 8'h00;
  logic [33:0] reqAddr = 34'h0;
  logic [7:0]  rdData, byteBusOut, devBus, lastCmd, lastData;
  logic [39:0] addrReg;
  logic        reqReady, rdValid, devReady, chipEnableN, cmdLatch, addrLatch;
  logic        writeStrobeN, readStrobeN, writeProtectN, byteBusOe, devOe, pullLow;
  int          failCount = 0, totalChecks = 0, cycles = 0;
  // Released bus shows a changing pattern; ready line pulled up
  wire logic [7:0] busLevel = byteBusOe ? byteBusOut : devOe ? devBus : ~lastLevel;
  wire logic readyBusyN = !pullLow;
  localparam logic [33:0] ADDR = {11'h5A5, 1'b1, 8'hC3, 14'h2BCD};
  // Rows: op, register picked (0-4 address byte, 5 command, 6 data), byte, expected
  localparam logic [21:0] ROWS [9] = '{
    {3'h0, 3'h5, 8'h80, 8'h80}, {3'h1, 3'h0, 8'hFF, 8'hFF}, {3'h1, 3'h1, 8'hFF, 8'h3F},
    {3'h1, 3'h2, 8'hFF, 8'hFF}, {3'h1, 3'h3, 8'hFF, 8'hFF}, {3'h1, 3'h4, 8'hFF, 8'h0F},
    {3'h1, 3'h4, 8'h77, 8'h0F}, {3'h3, 3'h6, 8'h5A, 8'h5A}, {3'h0, 3'h5, 8'h70, 8'h70}};

  nandh_ctrl u_nandh_ctrl (
    .clk(clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
    .reqByte(reqByte), .reqAddr(reqAddr), .reqWaitReady(reqWaitReady),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .chipSelect(chipSelect),
    .writeAllow(writeAllow), .devReady(devReady), .chipEnableN(chipEnableN),
    .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobeN(writeStrobeN),
    .read_strobe_n(readStrobeN), .writeProtectN(writeProtectN),
    .readyBusyN(readyBusyN), .byteBusIn(busLevel), .byteBusOut(byteBusOut),
    .byteBusOe(byteBusOe));
  nandh_flash_model u_nandh_flash_model (
    .clk(clk), .ceN(chipEnableN), .cle(cmdLatch), .ale(addrLatch), .weN(writeStrobeN),
    .readN(readStrobeN), .wpN(writeProtectN), .busIn(busLevel), .busOut(devBus),
    .busOe(devOe), .pullLow(pullLow), .lastCmd(lastCmd), .lastData(lastData),
    .addrReg(addrReg));

  // Clock, bus history and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    lastLevel <= busLevel;
    cycles++;
    if (cycles == 6000) begin
      failCount++;
      reportAndStop();
    end
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 3000);
    if (n >= 3000) failCount++;
  endtask
  // One request, held until taken, then run to completion
  task automatic doReq(input logic [2:0] op, input logic [7:0] b, input logic [33:0] a);
    reqOp    = op;
    reqByte  = b;
    reqAddr  = a;
    reqValid = 1'b1;
    waitIdle();
    @(posedge clk);
    #1 reqValid = 1'b0;
    reqOp        = 3'h0;
    reqWaitReady = 1'b0;
    waitIdle();
    @(posedge clk);
    #1;
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] seen;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    writeAllow = 1'b1;
    foreach (ROWS[i]) begin
      doReq(ROWS[i][21:19], ROWS[i][15:8], 34'h0);
      seen = ROWS[i][18:16] == 3'h5 ? lastCmd : ROWS[i][18:16] == 3'h6 ? lastData
           : addrReg[8*ROWS[i][18:16]+:8];
      check("latched byte", 40'(seen), 40'(ROWS[i][7:0]));
    end
    $display("test rows done");
    // Select held, then released so an idle device may sleep
    check("select held", 40'(chipEnableN), 40'h0);
    chipSelect = 1'b0;
    repeat (2) @(posedge clk);
    #1 check("select released", 40'(chipEnableN), 40'h1);
    chipSelect = 1'b1;
    $display("test select done");
    // Reset in mid-run drives pins idle
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 check("reset pins", 40'({chipEnableN, cmdLatch, addrLatch, writeStrobeN, readStrobeN,
                               writeProtectN, byteBusOe, rdValid}), 40'h98);
    srst = 1'b0;
    $display("test reset done");
    // Five-cycle address, then reads until the buffer refuses
    doReq(3'h0, 8'h00, 34'h0);
    doReq(3'h2, 8'h00, ADDR);
    check("address", addrReg, {4'h0, 11'h5A5, 1'b1, 8'hC3, 2'h0, 14'h2BCD});
    repeat (4) doReq(3'h4, 8'h00, 34'h0);
    reqOp    = 3'h4;
    reqValid = 1'b1;
    repeat (20) @(negedge clk);
    check("full refusal", 40'({reqReady, rdValid}), 40'h1);
    @(posedge clk);
    #1 reqValid = 1'b0;
    reqOp = 3'h0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      check("read byte", 40'({rdValid, rdData}), 40'({1'b1, (8'hCD + 8'(i)) ^ 8'h3C}));
      @(posedge clk);
      #1 rdReady = 1'b1;
      @(posedge clk);
      #1 rdReady = 1'b0;
    end
    @(negedge clk);
    check("drained", 40'(rdValid), 40'h0);
    @(posedge clk);
    #1 $display("test read done");
    // Program attempt under write protect leaves device ready
    writeAllow = 1'b0;
    doReq(3'h0, 8'h80, 34'h0);
    doReq(3'h2, 8'h00, ADDR);
    doReq(3'h3, 8'h11, 34'h0);
    doReq(3'h0, 8'h10, 34'h0);
    doReq(3'h5, 8'h00, 34'h0);
    check("protected", 40'({devReady, pullLow}), 40'h2);
    $display("test protect done");
    // Real program: busy seen, next command held off until ready
    writeAllow = 1'b1;
    doReq(3'h0, 8'h10, 34'h0);
    repeat (12) @(posedge clk);
    #1 check("busy seen", 40'({devReady, pullLow}), 40'h1);
    reqWaitReady = 1'b1;
    doReq(3'h0, 8'h70, 34'h0);
    check("waited ready", 40'({lastCmd, pullLow}), 40'h0E0);
    $display("test busy done");
    reportAndStop();
  end
endmodule // testbench
`default_nettype wire
